/* hdl/smic_pkg.sv */
// ***********************************************
// shared constants and types
// ***********************************************
package smic_pkg;

	// widths
	localparam int                 CNT_W     = 16;
	localparam int                 MODE_W    = 3;

	// values after reset, and the count of one
	localparam logic [CNT_W-1:0]   CNT_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]   CNT_ONE   = 16'h0001;
	localparam logic               OUT_RST   = 1'h1;
	localparam logic               SYNC_RST  = 1'h0;

	// setup modes
	typedef enum logic [MODE_W-1:0] {
		SMIC_M_TERM    = 3'h0,
		SMIC_M_ONESHOT = 3'h1,
		SMIC_M_RATE    = 3'h2,
		SMIC_M_SQUARE  = 3'h3,
		SMIC_M_SW_STB  = 3'h4,
		SMIC_M_HW_STB  = 3'h5
	} smic_mode_e;

	// sequencer states
	typedef enum logic [2:0] {
		SMIC_ST_IDLE   = 3'h0,
		SMIC_ST_WAIT   = 3'h1,
		SMIC_ST_RUN    = 3'h2,
		SMIC_ST_STROBE = 3'h3,
		SMIC_ST_DONE   = 3'h4
	} smic_state_e;

endpackage

/* hdl/smic_pin_sync.sv */
`timescale 1ns/1ps
// ***********************************************
// two-stage pin synchroniser with rise detect
// ***********************************************
module smic_pin_sync
	import smic_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// pin side
	input  wire logic pin_in,
	// synchronised side
	output logic      level,
	output logic      rise
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_ff <= SYNC_RST;
			sync_ff <= SYNC_RST;
			prev_ff <= SYNC_RST;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise  = sync_ff & ~prev_ff;

endmodule

/* hdl/smic_counter.sv */
// Overview of operation
// - mode 0 drives output low on mode write; counts only while gate high.
// - mode 0 raises output at terminal count; holds high until new mode or new count write.
// - mode 1 drives output low on count after gate rise; high at terminal count.
// - mode 2 pulses output low one counter clock period when count expires.
// - mode 2 loaded count sets periods between successive low pulses.
// - mode 3 square wave, half count high, half count low, repeating.
// - mode 4 output starts high; counts only while gate high.
// - mode 4 terminal count drives output low one clock pulse, then high.
// - mode 5 as mode 4 but gate rising edge triggers counting.
`timescale 1ns/1ps
module smic_counter
	import smic_pkg::*;
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// setup from software
	input  wire logic             mode_wr,
	input  wire logic [MODE_W-1:0] mode_val,
	input  wire logic             count_wr,
	input  wire logic [CNT_W-1:0] count_val,
	// counter pins
	input  wire logic             cnt_clk_pin,
	input  wire logic             gate_pin,
	output logic                  counter_out,
	// status
	output logic                  terminal_count_reached,
	output logic [CNT_W-1:0]      count_now,
	output logic                  counting
);

	// ***********************************************
	// helpers
	// ***********************************************
	function automatic logic edge_mode(input smic_mode_e m);
		edge_mode = (m == SMIC_M_ONESHOT) || (m == SMIC_M_HW_STB);
	endfunction

	function automatic logic [CNT_W-1:0] hi_len(input logic [CNT_W-1:0] n);
		hi_len = n - (n >> 1);
	endfunction

	function automatic logic [CNT_W-1:0] lo_len(input logic [CNT_W-1:0] n);
		lo_len = ((n >> 1) == CNT_RST) ? CNT_ONE : (n >> 1);
	endfunction

	// ***********************************************
	// registers
	// ***********************************************
	smic_mode_e       mode_ff;
	smic_mode_e       nxt_mode;
	smic_state_e      state_ff;
	smic_state_e      nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] reload_ff;
	logic [CNT_W-1:0] nxt_reload;
	logic             out_ff;
	logic             nxt_out;
	logic             tc_ff;
	logic             nxt_tc;
	logic             run_ff;
	logic             nxt_run;

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	logic src_level;
	logic src_tick;
	logic gate_level;
	logic gate_rise;

	smic_pin_sync u_src_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin_in  (cnt_clk_pin),
		.level   (src_level),
		.rise    (src_tick)
	);

	smic_pin_sync u_gate_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin_in  (gate_pin),
		.level   (gate_level),
		.rise    (gate_rise)
	);

	// ***********************************************
	// decode
	// ***********************************************
	wire              mode_ok    = (mode_val <= MODE_W'(SMIC_M_HW_STB));
	wire              take_mode  = mode_wr & mode_ok;
	wire              take_count = count_wr & ~take_mode;
	wire smic_mode_e  new_mode   = smic_mode_e'(mode_val);
	wire              level_en   = ~edge_mode(mode_ff) & gate_level;
	wire              tick_en    = src_tick & (edge_mode(mode_ff) | level_en);
	wire              at_end     = (cnt_ff == CNT_ONE);
	wire [CNT_W-1:0]  cnt_dec    = cnt_ff - CNT_ONE;
	wire              trig       = gate_rise & edge_mode(mode_ff) &
	                               (state_ff != SMIC_ST_IDLE);

	// ***********************************************
	// next state
	// ***********************************************
	always_comb begin
		nxt_mode   = mode_ff;
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_reload = reload_ff;
		nxt_out    = out_ff;
		nxt_tc     = 1'b0;
		if (take_mode) begin
			nxt_mode  = new_mode;
			nxt_state = SMIC_ST_IDLE;
			nxt_out   = (new_mode != SMIC_M_TERM);
		end else if (take_count) begin
			nxt_reload = count_val;
			if (edge_mode(mode_ff)) begin
				nxt_state = SMIC_ST_WAIT;
				nxt_out   = 1'b1;
			end else begin
				nxt_state = SMIC_ST_RUN;
				nxt_cnt   = (mode_ff == SMIC_M_SQUARE) ? hi_len(count_val) : count_val;
				nxt_out   = (mode_ff != SMIC_M_TERM);
			end
		end else if (trig) begin
			nxt_state = SMIC_ST_RUN;
			nxt_cnt   = reload_ff;
		end else if (tick_en) begin
			case (state_ff)
				SMIC_ST_RUN: begin
					case (mode_ff)
						SMIC_M_TERM: begin
							nxt_cnt = cnt_dec;
							if (at_end) begin
								nxt_out   = 1'b1;
								nxt_tc    = 1'b1;
								nxt_state = SMIC_ST_DONE;
							end
						end
						SMIC_M_ONESHOT: begin
							nxt_cnt = cnt_dec;
							nxt_out = 1'b0;
							if (at_end) begin
								nxt_out   = 1'b1;
								nxt_tc    = 1'b1;
								nxt_state = SMIC_ST_DONE;
							end
						end
						SMIC_M_RATE: begin
							if (at_end) begin
								nxt_out = 1'b0;
								nxt_tc  = 1'b1;
								nxt_cnt = reload_ff;
							end else begin
								nxt_out = 1'b1;
								nxt_cnt = cnt_dec;
							end
						end
						SMIC_M_SQUARE: begin
							if (at_end) begin
								nxt_out = ~out_ff;
								nxt_tc  = ~out_ff;
								nxt_cnt = out_ff ? lo_len(reload_ff) : hi_len(reload_ff);
							end else begin
								nxt_cnt = cnt_dec;
							end
						end
						default: begin
							nxt_cnt = cnt_dec;
							if (at_end) begin
								nxt_out   = 1'b0;
								nxt_tc    = 1'b1;
								nxt_state = SMIC_ST_STROBE;
							end
						end
					endcase
				end
				SMIC_ST_STROBE: begin
					nxt_out   = 1'b1;
					nxt_state = SMIC_ST_DONE;
				end
				default: begin
					nxt_state = state_ff;
				end
			endcase
		end
	end

	assign nxt_run = (nxt_state == SMIC_ST_RUN) | (nxt_state == SMIC_ST_STROBE);

	// ***********************************************
	// state flops
	// ***********************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_ff   <= SMIC_M_TERM;
			state_ff  <= SMIC_ST_IDLE;
			cnt_ff    <= CNT_RST;
			reload_ff <= CNT_RST;
		end else begin
			mode_ff   <= nxt_mode;
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			reload_ff <= nxt_reload;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			out_ff <= OUT_RST;
			tc_ff  <= 1'b0;
			run_ff <= 1'b0;
		end else begin
			out_ff <= nxt_out;
			tc_ff  <= nxt_tc;
			run_ff <= nxt_run;
		end
	end

	// ***********************************************
	// outputs
	// ***********************************************
	assign counter_out            = out_ff;
	assign terminal_count_reached = tc_ff;
	assign count_now              = cnt_ff;
	assign counting               = run_ff;

endmodule

/* bench/smic_pin_model.sv */
`timescale 1ns/1ps
// ***********************************************
// counter clock and gate source
// ***********************************************
module smic_pin_model (
	// clock
	input  wire logic clock,
	// pins
	output logic      cnt_clk_pin,
	output logic      gate_pin
);
	initial begin
		cnt_clk_pin = 1'h0;
		gate_pin    = 1'h0;
	end
	// clock stands low between bursts
	task automatic ticks(input int n, input int half);
		repeat (n) begin
			@(negedge clock);
			cnt_clk_pin = 1'h1;
			repeat (half) @(negedge clock);
			cnt_clk_pin = 1'h0;
			repeat (half - 1) @(negedge clock);
		end
	endtask
	task automatic gate(input logic lvl);
		@(negedge clock);
		gate_pin = lvl;
		repeat (6) @(negedge clock);
	endtask
endmodule

/* bench/smic_counter_asserts.sv */
`timescale 1ns/1ps
// ***********************************************
// port checker
// ***********************************************
module smic_chk
	import smic_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              sys_rst,
	// setup
	input wire logic              mode_wr,
	input wire logic [MODE_W-1:0] mode_val,
	input wire logic              count_wr,
	input wire logic [CNT_W-1:0]  count_val,
	// pins and status
	input wire logic              cnt_clk_pin,
	input wire logic              gate_pin,
	input wire logic              counter_out,
	input wire logic              terminal_count_reached,
	input wire logic [CNT_W-1:0]  count_now,
	input wire logic              counting
);
	logic [MODE_W-1:0] mode_ff;
	logic [CNT_W-1:0]  load_ff;
	wire               mode_ok = mode_wr && (mode_val <= 3'h5);
	wire               tc      = terminal_count_reached;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_ff <= 3'h0;
			load_ff <= CNT_RST;
		end else begin
			if (mode_ok) mode_ff <= mode_val;
			if (count_wr && !mode_ok) load_ff <= count_val;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	mode0_low_a: assert property (mode_ok && mode_val == 3'h0 |=> !counter_out)
		else $error("mode 0 not low");
	gate_hold_a: assert property ((!gate_pin && !mode_wr && !count_wr &&
		(mode_ff == 3'h0 || mode_ff == 3'h4))[*6] |-> $stable(count_now)) else $error("gate");
	term_high_a: assert property (mode_ff == 3'h0 && tc |-> counter_out)
		else $error("mode 0 tc");
	hold_high_a: assert property (mode_ff == 3'h0 && counter_out && !mode_ok && !count_wr
		|=> counter_out) else $error("mode 0 hold");
	shot_end_a: assert property (mode_ff == 3'h1 && tc |-> counter_out)
		else $error("mode 1 tc");
	rate_low_a: assert property (mode_ff == 3'h2 && $fell(counter_out) |-> tc)
		else $error("mode 2 pulse");
	rate_load_a: assert property (mode_ff == 3'h2 && tc |-> count_now == load_ff)
		else $error("mode 2 reload");
	square_tc_a: assert property (mode_ff == 3'h3 && tc |-> counter_out)
		else $error("mode 3 tc");
	strobe_init_a: assert property (mode_ok && mode_val == 3'h4 |=> counter_out)
		else $error("mode 4 start");
	strobe_tc_a: assert property (mode_ff[2] && $fell(counter_out) |-> tc)
		else $error("strobe");
	tc_pulse_a: assert property (tc |=> !tc)
		else $error("tc width");
	load_cnt_a: assert property (count_wr && !mode_ok && !mode_ff[0]
		|=> count_now == load_ff) else $error("load");
	square_load_a: assert property (count_wr && !mode_ok && mode_ff == 3'h3
		|=> count_now == load_ff - (load_ff >> 1)) else $error("mode 3 load");
	tick_hold_a: assert property ((!cnt_clk_pin && !mode_wr && !count_wr &&
		!mode_ff[0])[*6] |-> $stable(count_now)) else $error("no tick");
	run_flag_a: assert property (tc && mode_ff[2:1] == 2'h0 |-> !counting)
		else $error("done flag");
endmodule

/* bench/six_mode_interval_counter_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); error_cnt++; end end
// ***********************************************
// bench top
// ***********************************************
module six_mode_interval_counter_test;
	logic        clock = 1'h0;
	logic        sys_rst = 1'h1;
	logic        mode_wr = 1'h0;
	logic [2:0]  mode_val = 3'h0;
	logic        count_wr = 1'h0;
	logic [15:0] count_val = 16'h0;
	logic        cnt_clk_pin, gate_pin, counter_out, tc, counting;
	logic [15:0] count_now;
	int          error_cnt = 0;
	int          compares = 0;
	int          cycles = 0;
	int          tc_cnt = 0;
	int          tc_base = 0;
	// mode count ticks out cnt chk
	logic [23:0] rows [16] = '{24'h032011, 24'h033101, 24'h131021, 24'h133101,
		24'h232111, 24'h233031, 24'h234121, 24'h341100, 24'h342000, 24'h344100,
		24'h353000, 24'h432111, 24'h433000, 24'h434100, 24'h521111, 24'h522000};
	smic_counter uut (.clock(clock), .sys_rst(sys_rst), .mode_wr(mode_wr),
		.mode_val(mode_val), .count_wr(count_wr), .count_val(count_val),
		.cnt_clk_pin(cnt_clk_pin), .gate_pin(gate_pin), .counter_out(counter_out),
		.terminal_count_reached(tc), .count_now(count_now), .counting(counting));
	smic_pin_model pm (.clock(clock), .cnt_clk_pin(cnt_clk_pin), .gate_pin(gate_pin));
	always #5 clock = ~clock;
	always @(negedge clock) begin
		if (tc === 1'h1) tc_cnt++;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic put(input logic mw, input logic cw, input logic [15:0] v);
		@(negedge clock);
		mode_wr   = mw;
		count_wr  = cw;
		mode_val  = v[2:0];
		count_val = v;
		@(negedge clock);
		mode_wr  = 1'h0;
		count_wr = 1'h0;
	endtask
	task automatic run(input logic [2:0] m, input logic [15:0] n, input int t, input int h);
		pm.gate(m != 3'h1 && m != 3'h5);
		put(1'h1, 1'h0, {13'h0, m});
		put(1'h0, 1'h1, n);
		if (gate_pin !== 1'h1) pm.gate(1'h1);
		pm.ticks(t, h);
		repeat (8) @(negedge clock);
	endtask
	initial begin
		repeat (10) @(negedge clock);
		sys_rst = 1'h0;
		for (int i = 0; i < 16; i++) begin
			run(rows[i][22:20], {12'h0, rows[i][19:16]}, rows[i][15:12], 2 + 4 * i[0]);
			`CHK("out", rows[i][8], counter_out)
			if (rows[i][0]) `CHK("count", {12'h0, rows[i][7:4]}, count_now)
			$display("test %0d done", i);
		end
		// gate low freezes mode 0
		run(3'h0, 16'h5, 1, 2);
		pm.gate(1'h0);
		pm.ticks(3, 2);
		repeat (8) @(negedge clock);
		`CHK("held", 16'h4, count_now)
		pm.gate(1'h1);
		tc_base = tc_cnt;
		pm.ticks(4, 2);
		repeat (8) @(negedge clock);
		`CHK("tc out", 1'h1, counter_out)
		`CHK("tc pulses", 1, tc_cnt - tc_base)
		put(1'h1, 1'h0, 16'h6);
		`CHK("mode 6", 1'h1, counter_out)
		put(1'h0, 1'h1, 16'h2);
		`CHK("refused", 1'h0, counter_out)
		`CHK("run", 1'h1, counting)
		$display("test gate done");
		sys_rst = 1'h1;
		repeat (3) @(negedge clock);
		sys_rst = 1'h0;
		`CHK("reset", 19'h40000, {counter_out, counting, tc, count_now})
		$display("test reset done");
		end_sim();
	end
endmodule
bind smic_counter smic_chk chk (.clock(clock), .sys_rst(sys_rst), .mode_wr(mode_wr),
	.mode_val(mode_val), .count_wr(count_wr), .count_val(count_val),
	.cnt_clk_pin(cnt_clk_pin), .gate_pin(gate_pin), .counter_out(counter_out),
	.terminal_count_reached(terminal_count_reached), .count_now(count_now),
	.counting(counting));
